// >>> pkg/tof_cfg_defines.vh
/*
 * register offsets, field positions, reset values and timing constants
 * for the echo front-end configuration and error flag register bank.
 * assumes inclusion by bare name from the design files.
 */
// Notes on behaviour
// - preamp_power_ctrl zero keeps preamp active; one bypasses and powers it down.
// - preamp_feedback_sel zero selects capacitive feedback, one resistive; reset capacitive.
// - interval count bits 9:8 come from preamp config bits 1:0, reset zero.
// - interval count bits 7:0 come from RW register at offset six, reset zero.
// - weak echo flag sets on timeout with a signal received but fewer qualified crossings than expected.
// - no echo flag sets on timeout with no signal received.
// - writing one to no echo bit resets and halts the measurement sequencer.
// - that same write clears the averaging counter and auto channel selection.
// - strong echo flag sets when echo amplitude exceeds the largest threshold.
// - strong echo reported only when threshold select holds its maximum code.
// - writing one to strong echo bit clears all flags and releases error pin.
// - error flag bits 7:3 are reserved and read as zero.
// - timeout control zero applies echo timeout; one disables it.
// - listen window ends after 128, 256, 512 or 1024 base periods; reset code one.
`ifndef TOF_CFG_DEFINES_VH
`define TOF_CFG_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PREAMP_CFG      4'h5
`define OFS_INTERVAL_LOW    4'h6
`define OFS_ERROR_FLAGS     4'h7
`define OFS_TIMEOUT_CFG     4'h8
`define OFS_ECHO_QUAL       4'hA
`define OFS_IRQ_STATUS      4'hB
`define OFS_IRQ_MASK        4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_PREAMP_POWER    3
`define BIT_PREAMP_FB       2
`define BIT_WEAK_ECHO       2
`define BIT_NO_ECHO         1
`define BIT_STRONG_ECHO     0
`define BIT_TIMEOUT_DIS     2
`define BIT_IRQ_DONE        3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PREAMP_CFG      8'h00
`define RST_INTERVAL_LOW    8'h00
`define RST_ERROR_FLAGS     3'h0
`define RST_TIMEOUT_CFG     3'h1
`define RST_ECHO_QUAL       3'h0
`define RST_EXPECT_CROSS    3'h0
`define RST_IRQ             4'h0
`define THLD_MAX_CODE       3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WINDOW_BASE_PERIODS 11'h080
`define NO_ACCESS_DATA      8'h00

`endif

// >>> src/listen_timer.v
/*
 * listen window timer: counts base periods from the start of a listen
 * and raises a one-cycle expiry pulse after the selected window.
 * assumes base_tick is a one-cycle pulse on ref_clk.
 */
`timescale 1ns/1ps
`include "tof_cfg_defines.vh"

module listen_timer
(
    ref_clk,
    rst_n,
    run,
    base_tick,
    window_sel,
    expired
);
    input  wire       ref_clk;
    input  wire       rst_n;
    input  wire       run;
    input  wire       base_tick;
    input  wire [1:0] window_sel;
    output reg        expired;

    reg  [10:0] count_reg;
    wire [10:0] limit;

    // window doubles with each code step
    assign limit = `WINDOW_BASE_PERIODS << window_sel;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= 11'h000;
            expired   <= 1'b0;
        end
        else
        begin
            expired <= 1'b0;
            if (!run)
                count_reg <= 11'h000;
            else if (base_tick)
            begin
                if (count_reg == limit - 11'h001)
                begin
                    expired   <= 1'b1;
                    count_reg <= 11'h000;
                end
                else
                    count_reg <= count_reg + 11'h001;
            end
        end
    end
endmodule

// >>> src/tof_config_error_registers.v
/*
 * preamp configuration, interval count and measurement error flag
 * registers with an interrupt status/mask pair and error output pin.
 * assumes the host uses the plain strobe port on ref_clk and that the
 * analog echo indications arrive asynchronously from the front end.
 */
`timescale 1ns/1ps
`include "tof_cfg_defines.vh"

module tof_config_error_registers
(
    ref_clk,
    rst_n,
    addr,
    wr_data,
    wr_en,
    rd_en,
    rd_data,
    meas_start,
    base_tick,
    echo_seen,
    crossing_pulse,
    amp_over_max,
    preamp_power_ctrl,
    preamp_feedback_sel,
    interval_count,
    meas_active,
    avg_count,
    auto_channel,
    error_out_n,
    irq
);
    parameter CNT_W = 4;

    input  wire             ref_clk;
    input  wire             rst_n;
    input  wire [3:0]       addr;
    input  wire [7:0]       wr_data;
    input  wire             wr_en;
    input  wire             rd_en;
    output reg  [7:0]       rd_data;
    input  wire             meas_start;
    input  wire             base_tick;
    input  wire             echo_seen;
    input  wire             crossing_pulse;
    input  wire             amp_over_max;
    output reg              preamp_power_ctrl;
    output reg              preamp_feedback_sel;
    output reg  [9:0]       interval_count;
    output reg              meas_active;
    output reg  [CNT_W-1:0] avg_count;
    output reg              auto_channel;
    output reg              error_out_n;
    output reg              irq;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one compare shared by every write decode
    function reg_hit;
        input [3:0] a;
        input [3:0] ofs;
        begin
            reg_hit = (a == ofs);
        end
    endfunction

    // narrow registers read back with their unused bits at zero
    function [7:0] pad_nibble;
        input [3:0] v;
        begin
            pad_nibble = {4'h0, v};
        end
    endfunction

    // saturates so a noisy front end cannot wrap the crossing count
    function [2:0] sat_inc;
        input [2:0] v;
        begin
            if (v == 3'h7)
                sat_inc = v;
            else
                sat_inc = v + 3'h1;
        end
    endfunction

    // ------------------------------------------------------------
    // synchronisers for front-end indications
    // ------------------------------------------------------------
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg       cross_prev_reg;

    // front-end levels are asynchronous, so nothing reads the first stage
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg      <= 3'h0;
            sync2_reg      <= 3'h0;
            cross_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg      <= {amp_over_max, crossing_pulse, echo_seen};
            sync2_reg      <= sync1_reg;
            cross_prev_reg <= sync2_reg[1];
        end
    end

    // crossings count on the rising edge seen after synchronising
    wire echo_s     = sync2_reg[0];
    wire cross_rise = sync2_reg[1] & ~cross_prev_reg;
    wire amp_s      = sync2_reg[2];

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg [7:0] preamp_cfg_reg;
    reg [7:0] interval_low_reg;
    reg [2:0] timeout_cfg_reg;
    reg [2:0] echo_thld_reg;
    reg [2:0] expect_cross_reg;
    reg [2:0] flags_reg;
    reg [3:0] irq_status_reg;
    reg [3:0] irq_mask_reg;
    reg [2:0] cross_cnt_reg;
    reg       got_signal_reg;
    reg       run_reg;

    wire wr_preamp  = wr_en && reg_hit(addr, `OFS_PREAMP_CFG);
    wire wr_low     = wr_en && reg_hit(addr, `OFS_INTERVAL_LOW);
    wire wr_flags   = wr_en && reg_hit(addr, `OFS_ERROR_FLAGS);
    wire wr_timeout = wr_en && reg_hit(addr, `OFS_TIMEOUT_CFG);
    wire wr_qual    = wr_en && reg_hit(addr, `OFS_ECHO_QUAL);
    wire wr_istat   = wr_en && reg_hit(addr, `OFS_IRQ_STATUS);
    wire wr_imask   = wr_en && reg_hit(addr, `OFS_IRQ_MASK);

    // a halt write also wipes the averaging state so the next run starts clean
    wire seq_reset = wr_flags && wr_data[`BIT_NO_ECHO];
    wire clr_all   = wr_flags && wr_data[`BIT_STRONG_ECHO];

    // ------------------------------------------------------------
    // listen window timer
    // ------------------------------------------------------------
    // the timer restarts whenever the sequencer is idle, so a halt write
    // also discards a partly counted window
    wire timer_expired;

    listen_timer u_timer
    (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .run        (run_reg),
        .base_tick  (base_tick),
        .window_sel (timeout_cfg_reg[1:0]),
        .expired    (timer_expired)
    );

    // timeout only counts when enabled
    wire timeout_hit = timer_expired && !timeout_cfg_reg[`BIT_TIMEOUT_DIS];

    // ------------------------------------------------------------
    // error events
    // ------------------------------------------------------------
    wire set_weak   = timeout_hit && got_signal_reg &&
                      (cross_cnt_reg < expect_cross_reg);
    wire set_none   = timeout_hit && !got_signal_reg;
    // only the top threshold code can report an over-range echo; lower
    // codes would flag echoes that the comparator still qualifies
    wire set_strong = run_reg && amp_s &&
                      (echo_thld_reg == `THLD_MAX_CODE);
    wire [2:0] set_vec = {set_weak, set_none, set_strong};
    wire [3:0] ev_vec  = {timeout_hit, set_vec};

    // ------------------------------------------------------------
    // measurement tracking
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_reg        <= 1'b0;
            cross_cnt_reg  <= 3'h0;
            got_signal_reg <= 1'b0;
            avg_count      <= {CNT_W{1'b0}};
            auto_channel   <= 1'b0;
        end
        else if (seq_reset)
        begin
            run_reg        <= 1'b0;
            cross_cnt_reg  <= 3'h0;
            got_signal_reg <= 1'b0;
            avg_count      <= {CNT_W{1'b0}};
            auto_channel   <= 1'b0;
        end
        // a start while running is ignored; the halt write above has priority
        else if (meas_start && !run_reg)
        begin
            run_reg        <= 1'b1;
            cross_cnt_reg  <= 3'h0;
            got_signal_reg <= 1'b0;
        end
        else if (run_reg)
        begin
            if (echo_s)
                got_signal_reg <= 1'b1;
            if (cross_rise)
                cross_cnt_reg <= sat_inc(cross_cnt_reg);
            // window closes whether or not the timeout flag is enabled
            // and each closed window advances the averaging state
            if (timer_expired)
            begin
                run_reg      <= 1'b0;
                avg_count    <= avg_count + {{(CNT_W-1){1'b0}}, 1'b1};
                auto_channel <= ~auto_channel;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preamp_cfg_reg   <= `RST_PREAMP_CFG;
            interval_low_reg <= `RST_INTERVAL_LOW;
            timeout_cfg_reg  <= `RST_TIMEOUT_CFG;
            echo_thld_reg    <= `RST_ECHO_QUAL;
            expect_cross_reg <= `RST_EXPECT_CROSS;
            irq_mask_reg     <= `RST_IRQ;
        end
        else
        begin
            if (wr_preamp)
                preamp_cfg_reg <= wr_data;
            if (wr_low)
                interval_low_reg <= wr_data;
            // only the enable and window bits are kept; the rest read as zero
            if (wr_timeout)
                timeout_cfg_reg <= wr_data[2:0];
            // expected crossing count shares the threshold register
            if (wr_qual)
            begin
                echo_thld_reg    <= wr_data[2:0];
                expect_cross_reg <= wr_data[6:4];
            end
            if (wr_imask)
                irq_mask_reg <= wr_data[3:0];
        end
    end

    // ------------------------------------------------------------
    // error flags and interrupt status
    // ------------------------------------------------------------
    reg [2:0] flags_next;
    reg [3:0] irq_status_next;

    // set wins over a same-cycle clear so no event is lost
    always @*
    begin
        // a halt write clears only its own flag; the strong bit clears all
        flags_next = flags_reg | set_vec;
        if (clr_all)
            flags_next = set_vec;
        else if (seq_reset)
            flags_next = (flags_reg & 3'h5) | set_vec;
        irq_status_next = irq_status_reg | ev_vec;
        if (wr_istat)
            irq_status_next = (irq_status_reg & ~wr_data[3:0]) | ev_vec;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_reg      <= `RST_ERROR_FLAGS;
            irq_status_reg <= `RST_IRQ;
        end
        else
        begin
            flags_reg      <= flags_next;
            irq_status_reg <= irq_status_next;
        end
    end

    // ------------------------------------------------------------
    // output views
    // ------------------------------------------------------------
    // the interval count spans two registers with no latching, so a host
    // updating both halves may see one mixed value for a cycle
    wire       preamp_off       = preamp_cfg_reg[`BIT_PREAMP_POWER];
    wire       preamp_resistive = preamp_cfg_reg[`BIT_PREAMP_FB];
    wire [9:0] interval_view    = {preamp_cfg_reg[1:0], interval_low_reg};
    wire       error_level      = |flags_reg;
    wire       irq_level        = |(irq_status_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // outputs and read port
    // ------------------------------------------------------------
    // idle cycles read as zero so a stale answer is never taken for data;
    // reserved flag bits are padded here rather than stored
    reg [7:0] rd_next;

    always @*
    begin
        rd_next = `NO_ACCESS_DATA;
        if (rd_en)
        begin
            case (addr)
                `OFS_PREAMP_CFG:   rd_next = preamp_cfg_reg;
                `OFS_INTERVAL_LOW: rd_next = interval_low_reg;
                `OFS_ERROR_FLAGS:  rd_next = pad_nibble({1'b0, flags_reg});
                `OFS_TIMEOUT_CFG:  rd_next = pad_nibble({1'b0, timeout_cfg_reg});
                `OFS_ECHO_QUAL:    rd_next = {1'b0, expect_cross_reg, 1'b0, echo_thld_reg};
                `OFS_IRQ_STATUS:   rd_next = pad_nibble(irq_status_reg);
                `OFS_IRQ_MASK:     rd_next = pad_nibble(irq_mask_reg);
                default:           rd_next = `NO_ACCESS_DATA;
            endcase
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preamp_power_ctrl   <= 1'b0;
            preamp_feedback_sel <= 1'b0;
            interval_count      <= 10'h000;
            meas_active         <= 1'b0;
            error_out_n         <= 1'b1;
            irq                 <= 1'b0;
            rd_data             <= `NO_ACCESS_DATA;
        end
        else
        begin
            preamp_power_ctrl   <= preamp_off;
            preamp_feedback_sel <= preamp_resistive;
            interval_count      <= interval_view;
            meas_active         <= run_reg;
            error_out_n         <= ~error_level;
            irq                 <= irq_level;
            rd_data             <= rd_next;
        end
    end
endmodule

// >>> tb/host_model.sv
/* host microcontroller model: register strobe port and start request.
   assumes one ref_clk and that the bench calls one task at a time. */
`timescale 1ns/1ps

module host_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    output logic      [3:0] addr,
    output logic      [7:0] wr_data,
    output logic            wr_en,
    output logic            rd_en,
    output logic            meas_start
);
    initial
    begin
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        meas_start = 1'b0;
    end

    // released lines show the inverse so stale values never pass
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        addr <= ~a;
        // the answer stands only in the cycle after the strobe
        @(posedge ref_clk);
        d = rd_data;
    endtask

    // stale flags are looked at and cleared before every new run
    task automatic start(output logic [7:0] flags);
        rd(4'h7, flags);
        wr(4'h7, 8'h01);
        @(posedge ref_clk);
        meas_start <= 1'b1;
        @(posedge ref_clk);
        meas_start <= 1'b0;
    endtask
endmodule

// >>> tb/tof_config_error_registers_asserts.sv
/* port-level checker for the config and error flag bank.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps

module tof_config_error_registers_asserts
#(
    parameter CNT_W = 4
)
(
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic [3:0]       addr,
    input wire logic [7:0]       wr_data,
    input wire logic             wr_en,
    input wire logic             rd_en,
    input wire logic [7:0]       rd_data,
    input wire logic             meas_start,
    input wire logic             base_tick,
    input wire logic             echo_seen,
    input wire logic             crossing_pulse,
    input wire logic             amp_over_max,
    input wire logic             preamp_power_ctrl,
    input wire logic             preamp_feedback_sel,
    input wire logic [9:0]       interval_count,
    input wire logic             meas_active,
    input wire logic [CNT_W-1:0] avg_count,
    input wire logic             auto_channel,
    input wire logic             error_out_n,
    input wire logic             irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence wr_cfg;
        wr_en && addr == 4'h5 ##1 !(wr_en && addr == 4'h5);
    endsequence
    sequence wr_low;
        wr_en && addr == 4'h6 ##1 !(wr_en && addr == 4'h6);
    endsequence
    // idle first, so no flag can be set again by a running measurement
    sequence idle_clear_all;
        !meas_active [*3] ##0 (wr_en && addr == 4'h7 && wr_data[0]);
    endsequence
    sequence halt_write;
        wr_en && addr == 4'h7 && wr_data[1] ##1 !meas_start [*2];
    endsequence

    chk_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_rsvd_read_zero: assert property ($past(rd_en) && $past(addr) == 4'h7
        |-> rd_data[7:3] == 5'h00) else $error("reserved flag bits not zero");
    chk_unmapped_zero: assert property ($past(rd_en) && ($past(addr) < 4'h5
        || $past(addr) == 4'h9 || $past(addr) > 4'hC) |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    chk_count_low: assert property (wr_low |-> ##1
        interval_count[7:0] == $past(wr_data, 2)) else $error("count low bits wrong");
    chk_count_high: assert property (wr_cfg |-> ##1
        interval_count[9:8] == $past(wr_data[1:0], 2)) else $error("count high bits wrong");
    chk_preamp_mode: assert property (wr_cfg |-> ##1 preamp_power_ctrl == $past(wr_data[3], 2)
        && preamp_feedback_sel == $past(wr_data[2], 2)) else $error("preamp mode wrong");
    chk_halt_seq: assert property (halt_write |-> !meas_active && avg_count == '0
        && !auto_channel) else $error("sequencer not halted");
    chk_pin_release: assert property (idle_clear_all |-> ##2 error_out_n)
        else $error("error pin not released");
endmodule

bind tof_config_error_registers tof_config_error_registers_asserts #(.CNT_W(CNT_W))
    tof_config_error_registers_asserts_i (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .meas_start(meas_start), .base_tick(base_tick), .echo_seen(echo_seen),
    .crossing_pulse(crossing_pulse), .amp_over_max(amp_over_max),
    .preamp_power_ctrl(preamp_power_ctrl), .preamp_feedback_sel(preamp_feedback_sel),
    .interval_count(interval_count), .meas_active(meas_active), .avg_count(avg_count),
    .auto_channel(auto_channel), .error_out_n(error_out_n), .irq(irq));

// >>> tb/tof_config_error_registers_bench.sv
/* self-checking bench for the config and error flag bank.
   assumes the host model drives the register port and start request. */
`timescale 1ns/1ps

module tof_config_error_registers_bench;
    logic       ref_clk, rst_n, wr_en, rd_en, meas_start, base_tick;
    logic       echo_seen, crossing_pulse, amp_over_max, preamp_power_ctrl;
    logic       preamp_feedback_sel, meas_active, auto_channel, error_out_n, irq;
    logic [3:0] addr, avg_count;
    logic [7:0] wr_data, rd_data, d;
    logic [9:0] interval_count;
    int         errors, n_checks;
    // {addr, reset value} and {addr, write data, read back}
    logic [11:0] rst_tbl[7] = '{12'h500, 12'h600, 12'h700, 12'h801, 12'hA00, 12'hB00, 12'hC00};
    logic [19:0] tbl[9] = '{20'h6A5A5, 20'h50E0E, 20'h80707, 20'hA7777, 20'hC0F0F,
                            20'hC0000, 20'h7F800, 20'h3FF00, 20'hF0000};

    tof_config_error_registers tof_config_error_registers_i (.ref_clk(ref_clk),
        .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .meas_start(meas_start), .base_tick(base_tick),
        .echo_seen(echo_seen), .crossing_pulse(crossing_pulse), .amp_over_max(amp_over_max),
        .preamp_power_ctrl(preamp_power_ctrl), .preamp_feedback_sel(preamp_feedback_sel),
        .interval_count(interval_count), .meas_active(meas_active), .avg_count(avg_count),
        .auto_channel(auto_channel), .error_out_n(error_out_n), .irq(irq));
    host_model host_model_i (.ref_clk(ref_clk), .rd_data(rd_data), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .meas_start(meas_start));

    always #20 ref_clk = ~ref_clk;

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task results;
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            base_tick <= 1'b1;
            @(posedge ref_clk);
            base_tick <= 1'b0;
        end
    endtask

    // bounded wait on the error pin; running out counts as a mismatch
    task automatic wait_pin(input logic v);
        int k;
        for (k = 0; k < 20 && error_out_n !== v; k++)
            @(posedge ref_clk);
        if (error_out_n !== v)
        begin
            chk(error_out_n, v);
            results;
        end
    endtask

    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        base_tick = 1'b0;
        echo_seen = 1'b0;
        crossing_pulse = 1'b0;
        amp_over_max = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk(error_out_n, 1'b1);
        chk({preamp_power_ctrl, preamp_feedback_sel, interval_count}, 12'h000);
        foreach (rst_tbl[i])
        begin
            host_model_i.rd(rst_tbl[i][11:8], d);
            chk(d, rst_tbl[i][7:0]);
        end
        foreach (tbl[i])
        begin
            host_model_i.wr(tbl[i][19:16], tbl[i][15:8]);
            host_model_i.rd(tbl[i][19:16], d);
            chk(d, tbl[i][7:0]);
        end
        chk({preamp_power_ctrl, preamp_feedback_sel, interval_count}, 12'hEA5);
        // ----------------------------------------------------------------
        // no echo, window length, interrupt, halt
        // ----------------------------------------------------------------
        host_model_i.wr(4'h8, 8'h00);
        host_model_i.start(d);
        ticks(127);
        chk(meas_active, 1'b1);
        ticks(1);
        wait_pin(1'b0);
        chk({meas_active, auto_channel, avg_count}, 6'h11);
        host_model_i.rd(4'h7, d);
        chk(d, 8'h02);
        chk(irq, 1'b0);
        host_model_i.wr(4'hC, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b1);
        host_model_i.wr(4'hB, 8'h0F);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b0);
        host_model_i.wr(4'h7, 8'h01);
        wait_pin(1'b1);
        host_model_i.start(d);
        ticks(10);
        host_model_i.wr(4'h7, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk({meas_active, auto_channel, avg_count}, 6'h00);
        // ----------------------------------------------------------------
        // weak echo, strong echo gating, timeout disabled
        // ----------------------------------------------------------------
        host_model_i.wr(4'hA, 8'h36);
        host_model_i.start(d);
        echo_seen <= 1'b1;
        amp_over_max <= 1'b1;
        crossing_pulse <= 1'b1;
        repeat (4) @(posedge ref_clk);
        crossing_pulse <= 1'b0;
        host_model_i.rd(4'h7, d);
        chk(d, 8'h00);
        host_model_i.wr(4'hA, 8'h37);
        repeat (4) @(posedge ref_clk);
        host_model_i.rd(4'h7, d);
        chk(d, 8'h01);
        amp_over_max <= 1'b0;
        ticks(128);
        wait_pin(1'b0);
        host_model_i.rd(4'h7, d);
        chk(d, 8'h05);
        host_model_i.wr(4'h7, 8'h01);
        host_model_i.rd(4'h7, d);
        chk(d, 8'h00);
        echo_seen <= 1'b0;
        host_model_i.wr(4'h8, 8'h04);
        host_model_i.start(d);
        ticks(128);
        repeat (4) @(posedge ref_clk);
        host_model_i.rd(4'h7, d);
        chk({meas_active, d}, 9'h000);
        results;
    end
endmodule
